// File: adai_ctrl.sv
// module: controller driving a 64k x 4 multiplexed-address dram array
//
// Notes on behaviour
// - row byte latched by falling row strobe, then column byte by column strobe.
// - column strobe may drop once row hold time passed and column is on pins.
// - hold data around the strobing edge: column strobe or write-select.
// - in modify-write, output-drive high well before write data is driven.
// - page mode keeps row strobe low over several column cycles in one row.
// - every one of 256 rows refreshed at least once per 4 ms.
// - row-only refresh strobes each row with column strobe held high.
// - column strobe low before row strobe gives counter-addressed refresh.
// - hidden refresh keeps column strobe low after a read and cycles row strobe.
// - counter test flow: init counter, write rows, test-cycle check, complement.
// - after power-up wait 200 us then eight refresh cycles before use.
`timescale 1ns/1ps
`default_nettype none

module adai_ctrl #(
    parameter int unsigned INIT_WAIT_CYC = adai_pkg::INIT_WAIT_CYC
) (
    // clock, reset and enable
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               ce,
    // request side
    input  wire logic               reqValid,
    input  wire adai_pkg::adai_req_s reqIn,
    output logic                    reqReady,
    input  wire logic               useRasOnly,
    // answer side
    output logic                    rspValid,
    output logic [3:0]              rspData,
    // array pins
    output var adai_pkg::adai_pins_s pins,
    output logic [3:0]              dqOut,
    output logic                    dqOe,
    input  wire logic [3:0]         dqIn
);

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_PWR, ST_IDLE, ST_ROW, ST_COL, ST_CAS, ST_RMW_OE, ST_RMW_WE, ST_CASUP,
        ST_OPEN, ST_PRE, ST_HID_RP, ST_RFR, ST_CBR_LEAD, ST_CBR_RAS, ST_TST_UP
    } adai_state_e;

    adai_state_e          stReg, stNext;
    adai_pkg::adai_pins_s pinsReg, pinsNext;
    adai_pkg::adai_req_s  opReg, opNext;
    logic [15:0]          timerReg, timerNext;
    logic [3:0]           dqOutReg, dqOutNext;
    logic                 dqOeReg, dqOeNext;
    logic                 rspValidReg, rspValidNext;
    logic [3:0]           rspDataReg, rspDataNext;
    logic [3:0]           initLeftReg, initLeftNext;
    logic                 testReg, testNext;
    logic [7:0]           refRowReg, refRowNext;
    logic [15:0]          refCntReg;
    logic                 refPendReg;
    logic [15:0]          refAgeReg;
    logic [3:0]           dqSync;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic timerDone = (timerReg == 16'h0000);
    wire logic refTick   = (refCntReg == adai_pkg::REF_GAP_CYC - 16'h0001);
    wire logic isRead    = (opReg.op != adai_pkg::OP_WRITE);
    wire logic rowHit    = (adai_pkg::rowOf(reqIn.addr) == adai_pkg::rowOf(opReg.addr));
    wire logic idleTake  = (stReg == ST_IDLE) && (initLeftReg == 4'h0) && !refPendReg;
    wire logic pageTake  = (stReg == ST_OPEN) && !refPendReg && rowHit
                           && (reqIn.op != adai_pkg::OP_TEST);
    wire logic refStart  = (stNext == ST_RFR || stNext == ST_CBR_LEAD || stNext == ST_HID_RP)
                           && (stReg != stNext) && !testNext;

    assign reqReady = idleTake || pageTake;
    assign pins     = pinsReg;
    assign dqOut    = dqOutReg;
    assign dqOe     = dqOeReg;
    assign rspValid = rspValidReg;
    assign rspData  = rspDataReg;

    // data pins pass two flops before the sampling logic
    adai_sync #(.WIDTH(4)) dqSyncInst (
        .mclk    (mclk),
        .reset   (reset),
        .ce      (ce),
        .pinIn   (dqIn),
        .syncOut (dqSync)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        stNext       = stReg;
        pinsNext     = pinsReg;
        opNext       = opReg;
        timerNext    = timerDone ? timerReg : timerReg - 16'h0001;
        dqOutNext    = dqOutReg;
        dqOeNext     = dqOeReg;
        rspValidNext = 1'b0;
        rspDataNext  = rspDataReg;
        initLeftNext = initLeftReg;
        testNext     = testReg;
        refRowNext   = refRowReg;
        case (stReg)
            ST_PWR: begin
                if (timerDone) begin
                    stNext = ST_IDLE;
                end
            end
            ST_IDLE, ST_OPEN: begin
                if (stReg == ST_IDLE && (initLeftReg != 4'h0 || refPendReg)) begin
                    // init burst and periodic refresh share one path
                    if (initLeftReg != 4'h0) begin
                        initLeftNext = initLeftReg - 4'h1;
                    end
                    if (useRasOnly) begin
                        stNext         = ST_RFR;
                        pinsNext.addr  = refRowReg;
                        pinsNext.rasN  = 1'b0;
                        refRowNext     = refRowReg + 8'h01;
                        timerNext      = adai_pkg::RAS_CYC - 16'h0001;
                    end else begin
                        stNext        = ST_CBR_LEAD;
                        pinsNext.casN = 1'b0;
                        timerNext     = adai_pkg::CBR_LEAD_CYC - 16'h0001;
                    end
                end else if (reqValid && reqReady) begin
                    opNext = reqIn;
                    if (reqIn.op == adai_pkg::OP_TEST) begin
                        // counter test opens with a counter refresh
                        testNext      = 1'b1;
                        stNext        = ST_CBR_LEAD;
                        pinsNext.casN = 1'b0;
                        timerNext     = adai_pkg::CBR_LEAD_CYC - 16'h0001;
                    end else if (stReg == ST_OPEN) begin
                        stNext = ST_COL;   // row stays latched
                    end else begin
                        stNext        = ST_ROW;
                        pinsNext.addr = adai_pkg::rowOf(reqIn.addr);
                        pinsNext.rasN = 1'b0;
                        timerNext     = adai_pkg::ROW_HOLD_CYC - 16'h0001;
                    end
                end else if (stReg == ST_OPEN) begin
                    // close the page: refresh due, another row or a counter test wanted
                    if (refPendReg || reqValid) begin
                        stNext        = ST_PRE;
                        pinsNext.rasN = 1'b1;
                        timerNext     = adai_pkg::PRE_CYC - 16'h0001;
                    end
                end
            end
            ST_ROW: begin
                if (timerDone) begin
                    stNext = ST_COL;   // row hold met before column goes on
                end
            end
            ST_COL: begin
                // column onto the pins one cycle before the strobe falls
                stNext        = ST_CAS;
                pinsNext.addr = adai_pkg::colOf(opReg.addr);
                pinsNext.weN  = isRead;
                dqOeNext      = !isRead;  // early write data set up now
                dqOutNext     = opReg.wdata;
                timerNext     = adai_pkg::CAS_CYC;
            end
            ST_TST_UP: begin
                if (timerDone) begin
                    stNext = ST_COL;   // second column fall carries the column
                end
            end
            ST_CAS: begin
                if (pinsReg.casN) begin
                    pinsNext.casN = 1'b0;
                    pinsNext.oeN  = !isRead;   // early write leaves drive high
                    timerNext     = isRead ? adai_pkg::READ_CYC : adai_pkg::CAS_CYC;
                end else if (timerDone) begin
                    if (isRead) begin
                        rspValidNext = 1'b1;
                        rspDataNext  = dqSync;
                    end
                    if (opReg.op == adai_pkg::OP_RMW || opReg.op == adai_pkg::OP_TEST) begin
                        stNext       = ST_RMW_OE;
                        pinsNext.oeN = 1'b1;
                        timerNext    = adai_pkg::OE_TO_DIN_CYC - 16'h0001;
                    end else if (opReg.op == adai_pkg::OP_READ && refPendReg && !useRasOnly) begin
                        // column strobe stays low, read data stays on pins
                        stNext        = ST_HID_RP;
                        pinsNext.rasN = 1'b1;
                        timerNext     = adai_pkg::PRE_CYC - 16'h0001;
                    end else begin
                        stNext = ST_CASUP;
                    end
                end
            end
            ST_RMW_OE: begin
                if (timerDone) begin
                    // data goes out a cycle before write-select falls
                    stNext    = ST_RMW_WE;
                    dqOeNext  = 1'b1;
                    dqOutNext = opReg.wdata;
                end
            end
            ST_RMW_WE: begin
                if (pinsReg.weN) begin
                    // write-select strobes data that already stands
                    pinsNext.weN = 1'b0;
                    timerNext    = adai_pkg::WP_CYC - 16'h0001;
                end else if (timerDone) begin
                    stNext = ST_CASUP;
                end
            end
            ST_CASUP: begin
                if (!pinsReg.casN || pinsReg.oeN == 1'b0) begin
                    pinsNext.casN = 1'b1;
                    pinsNext.oeN  = 1'b1;
                    pinsNext.weN  = 1'b1;
                    dqOeNext      = 1'b0;
                    // counter test row pulse is far longer than a page gap
                    timerNext     = testReg ? adai_pkg::TST_RAS_CYC
                                            : adai_pkg::CASPRE_CYC - 16'h0001;
                end else if (timerDone) begin
                    if (testReg) begin
                        testNext      = 1'b0;
                        stNext        = ST_PRE;
                        pinsNext.rasN = 1'b1;
                        timerNext     = adai_pkg::PRE_CYC - 16'h0001;
                    end else begin
                        stNext = ST_OPEN;
                    end
                end
            end
            ST_HID_RP: begin
                if (timerDone) begin
                    stNext        = ST_CBR_RAS;
                    pinsNext.rasN = 1'b0;
                    timerNext     = adai_pkg::RAS_CYC - 16'h0001;
                end
            end
            ST_CBR_LEAD: begin
                if (timerDone) begin
                    stNext        = ST_CBR_RAS;
                    pinsNext.rasN = 1'b0;
                    timerNext     = testReg ? adai_pkg::CBR_HOLD_CYC - 16'h0001
                                            : adai_pkg::RAS_CYC - 16'h0001;
                end
            end
            ST_CBR_RAS: begin
                if (timerDone) begin
                    if (testReg) begin
                        stNext        = ST_TST_UP;
                        pinsNext.casN = 1'b1;
                        timerNext     = adai_pkg::TST_CASPRE_CYC - 16'h0001;
                    end else begin
                        stNext        = ST_PRE;
                        pinsNext      = '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, oeN: 1'b1,
                                          addr: pinsReg.addr};
                        timerNext     = adai_pkg::PRE_CYC - 16'h0001;
                    end
                end
            end
            ST_RFR: begin
                if (timerDone) begin
                    stNext        = ST_PRE;
                    pinsNext.rasN = 1'b1;
                    timerNext     = adai_pkg::PRE_CYC - 16'h0001;
                end
            end
            ST_PRE: begin
                pinsNext.casN = 1'b1;
                pinsNext.oeN  = 1'b1;
                pinsNext.weN  = 1'b1;
                dqOeNext      = 1'b0;
                if (timerDone) begin
                    stNext = ST_IDLE;
                end
            end
            default: begin
                stNext = ST_PRE;
            end
        endcase
    end

    // state registers, all strobe pins idle high and address 8'h00 after reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            stReg       <= ST_PWR;
            pinsReg     <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: 8'h00};
            opReg       <= '0;
            timerReg    <= 16'(INIT_WAIT_CYC - 1);
            dqOutReg    <= 4'h0;
            dqOeReg     <= 1'b0;
            rspValidReg <= 1'b0;
            rspDataReg  <= 4'h0;
            initLeftReg <= adai_pkg::INIT_REFRESHES;
            testReg     <= 1'b0;
            refRowReg   <= 8'h00;
        end else if (ce) begin
            stReg       <= stNext;
            pinsReg     <= pinsNext;
            opReg       <= opNext;
            timerReg    <= timerNext;
            dqOutReg    <= dqOutNext;
            dqOeReg     <= dqOeNext;
            rspValidReg <= rspValidNext;
            rspDataReg  <= rspDataNext;
            initLeftReg <= initLeftNext;
            testReg     <= testNext;
            refRowReg   <= refRowNext;
        end
    end

    // refresh pacing: a new tick wins over the clear of the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            refCntReg  <= 16'h0000;
            refPendReg <= 1'b0;
            refAgeReg  <= 16'h0000;
        end else if (ce) begin
            refCntReg  <= refTick ? 16'h0000 : refCntReg + 16'h0001;
            refPendReg <= refTick || (refPendReg && !refStart);
            // power-up pause is not a refresh gap: age starts with the first refresh
            refAgeReg  <= (refStart || stReg == ST_PWR) ? 16'h0000
                        : (refAgeReg == 16'hFFFF ? refAgeReg : refAgeReg + 16'h0001);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int unsigned REF_AGE_MAX = 2 * adai_pkg::REF_GAP_CYC;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset || !ce);

    AST_ROW_HOLD: assert property ($fell(pins.rasN) && pins.casN |-> pins.casN [*2])
        else $error("column strobe fell inside row hold");
    AST_CBR_LEAD: assert property ($fell(pins.rasN) && !pins.casN |-> !$past(pins.casN, 2))
        else $error("column strobe lead before row strobe too short");
    AST_EARLY_DATA: assert property ($fell(pins.casN) && !pins.weN |-> dqOe)
        else $error("early write data not driven at column strobe fall");
    AST_NO_FIGHT: assert property (dqOe |-> pins.oeN)
        else $error("data driven while array output enabled");
    AST_OE_GAP: assert property ($rose(pins.oeN) |-> !dqOe [*3])
        else $error("data driven too soon after output-drive rose");
    AST_RAS_ONLY: assert property (stReg == ST_RFR |-> pins.casN && pins.weN && !dqOe)
        else $error("row-only refresh with column strobe or data active");
    AST_REF_AGE: assert property (refAgeReg <= 16'(REF_AGE_MAX))
        else $error("refresh interval exceeded");
    AST_INIT_DONE: assert property (stReg == ST_ROW |-> initLeftReg == 4'h0)
        else $error("access before init refreshes complete");
    AST_PAGE_ROW: assert property (stReg == ST_COL && $past(stReg) == ST_OPEN |-> !pins.rasN)
        else $error("page access with row strobe released");

    COV_EARLY_WRITE: cover property ($fell(pins.casN) && !pins.weN);
    COV_RMW: cover property (stReg == ST_RMW_WE && !testReg);
    COV_PAGE: cover property (stReg == ST_OPEN ##1 stReg == ST_COL);
    COV_HIDDEN: cover property (stReg == ST_HID_RP);
    COV_TEST: cover property (stReg == ST_TST_UP);

endmodule

`default_nettype wire

// File: adai_pkg.sv
// package: constants, types and helpers for the dram array controller
package adai_pkg;

    // ------------------------------------------------------------
    // clock and timing figures
    // ------------------------------------------------------------
    localparam int unsigned CLK_PS = 10000;

    // cycles for a least time: round up, never below one
    function automatic logic [15:0] nsToCyc(input int unsigned ns);
        int unsigned c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        if (c == 0) begin
            c = 1;
        end
        return c[15:0];
    endfunction

    localparam int unsigned ROW_ADDR_HOLD_TIME_NS        = 15;
    localparam int unsigned REFRESH_COL_LEAD_TIME_NS     = 20;
    localparam int unsigned DRIVE_TO_DATA_IN_DELAY_NS    = 30;
    localparam int unsigned DATA_FLOAT_TO_DRIVE_DELAY_NS = 0;
    localparam int unsigned ROW_ACCESS_TIME_NS           = 150;
    localparam int unsigned DRIVE_ACCESS_TIME_NS         = 40;
    localparam int unsigned ROW_PRECHARGE_NS             = 100;
    localparam int unsigned ROW_PULSE_NS                 = 150;
    localparam int unsigned COL_PULSE_NS                 = 75;
    localparam int unsigned COL_PRECHARGE_NS             = 60;
    localparam int unsigned WRITE_PULSE_NS               = 35;
    localparam int unsigned REFRESH_COL_HOLD_NS          = 30;
    localparam int unsigned TEST_COL_PRECHARGE_NS        = 70;
    localparam int unsigned TEST_ROW_PULSE_NS            = 395;
    localparam int unsigned REFRESH_PERIOD_US            = 4000;
    localparam int unsigned POWER_UP_PAUSE_US            = 200;
    localparam int unsigned REFRESH_ROWS                 = 256;
    localparam logic [3:0]  INIT_REFRESHES               = 4'h8;
    localparam int unsigned SYNC_STAGES                  = 2;

    localparam logic [15:0] ROW_HOLD_CYC  = nsToCyc(ROW_ADDR_HOLD_TIME_NS);
    localparam logic [15:0] CBR_LEAD_CYC  = nsToCyc(REFRESH_COL_LEAD_TIME_NS);
    localparam logic [15:0] OE_TO_DIN_CYC = nsToCyc(DRIVE_TO_DATA_IN_DELAY_NS);
    // read sample point: slower of both access paths plus the synchroniser
    localparam logic [15:0] READ_CYC      = nsToCyc(ROW_ACCESS_TIME_NS)
                                            + 16'(SYNC_STAGES);
    localparam logic [15:0] PRE_CYC       = nsToCyc(ROW_PRECHARGE_NS);
    localparam logic [15:0] RAS_CYC       = nsToCyc(ROW_PULSE_NS);
    localparam logic [15:0] CAS_CYC       = nsToCyc(COL_PULSE_NS);
    localparam logic [15:0] CASPRE_CYC    = nsToCyc(COL_PRECHARGE_NS);
    localparam logic [15:0] WP_CYC        = nsToCyc(WRITE_PULSE_NS);
    localparam logic [15:0] CBR_HOLD_CYC  = nsToCyc(REFRESH_COL_HOLD_NS);
    localparam logic [15:0] TST_CASPRE_CYC = nsToCyc(TEST_COL_PRECHARGE_NS);
    localparam logic [15:0] TST_RAS_CYC   = nsToCyc(TEST_ROW_PULSE_NS);
    // per-row refresh spacing, a longest time so it rounds down
    localparam int unsigned REF_ROW_NS    = REFRESH_PERIOD_US * 1000 / REFRESH_ROWS;
    localparam logic [15:0] REF_GAP_CYC   = 16'(REF_ROW_NS * 1000 / CLK_PS);
    localparam int unsigned INIT_WAIT_CYC = POWER_UP_PAUSE_US * 1000000 / CLK_PS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW, OP_TEST} adai_op_e;

    typedef struct packed {
        adai_op_e    op;
        logic [15:0] addr;   // row in the high byte, column in the low byte
        logic [3:0]  wdata;
    } adai_req_s;

    typedef struct packed {
        logic       rasN;
        logic       casN;
        logic       weN;
        logic       oeN;
        logic [7:0] addr;
    } adai_pins_s;

    function automatic logic [7:0] rowOf(input logic [15:0] a);
        return a[15:8];
    endfunction

    function automatic logic [7:0] colOf(input logic [15:0] a);
        return a[7:0];
    endfunction

endpackage

// File: adai_sync.sv
// module: two-stage synchroniser for the data pins coming back from the array
`timescale 1ns/1ps
`default_nettype none

module adai_sync #(
    parameter int unsigned WIDTH = 4
) (
    // clock, reset and enable
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             ce,
    // pin side and synchronised side
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1Reg;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1Reg <= '0;
            syncOut   <= '0;
        end else if (ce) begin
            stage1Reg <= pinIn;
            syncOut   <= stage1Reg;
        end
    end

endmodule

`default_nettype wire

// File: adai_dram_model.sv
// model: behavioural 64k x 4 dram array at the controller's pins
`timescale 1ns/1ps
`default_nettype none
module adai_dram_model (
    // strobes, address and data from the controller
    input  wire adai_pkg::adai_pins_s pins,
    input  wire logic [3:0]           dqOut,
    input  wire logic                 dqOe,
    // data pins back to the controller
    output logic [3:0]                dqIn
);
    logic [3:0] mem [0:65535];
    logic [7:0] rowReg;
    logic [7:0] colReg;
    logic [7:0] cnt   = 8'h00;
    logic       cbr   = 1'b0;
    logic       early = 1'b0;
    logic       open  = 1'b0;
    wire  [3:0] rdVal = mem[{rowReg, colReg}];
    wire        drv   = open && !pins.casN && !pins.oeN && !early;
    // a floating pin shows the inverse, so a float never passes for data
    assign dqIn = drv ? rdVal : ~rdVal;
    // row fall: column low first means counter refresh, else latch row
    always @(negedge pins.rasN) begin
        cbr = !pins.casN;
        if (!cbr) begin
            rowReg = pins.addr;
            open = 1'b0;
        end
    end
    always @(posedge pins.rasN) begin
        if (cbr) cnt = cnt + 8'h01;
    end
    // column fall with row low starts an access, counter row in a test cycle
    always @(negedge pins.casN) begin
        if (!pins.rasN) begin
            if (cbr) rowReg = cnt;
            colReg = pins.addr;
            open = 1'b1;
            early = !pins.weN;
            if (early) mem[{rowReg, colReg}] = dqOe ? dqOut : ~dqOut;
        end
    end
    // delayed write: data strobed by the write-select fall
    always @(negedge pins.weN) begin
        if (open && !pins.casN && !early) mem[{rowReg, colReg}] = dqOe ? dqOut : ~dqOut;
    end
endmodule
`default_nettype wire

// File: test_async_dram_array_interface.sv
// testbench: controller against the behavioural dram array
`timescale 1ns/1ps
`default_nettype none
module test_async_dram_array_interface;
    logic                 mclk, reset, ce, reqValid, reqReady, useRasOnly, rspValid, dqOe;
    adai_pkg::adai_req_s  reqIn;
    adai_pkg::adai_pins_s pins;
    logic [3:0]           rspData, dqOut, dqIn;
    logic [3:0]           expQ [$];
    logic [15:0]          adr [4];
    logic [3:0]           dat [4];
    int                   mismatches, n_checks;
    adai_ctrl #(.INIT_WAIT_CYC(20)) adai_ctrl_inst (.mclk(mclk), .reset(reset), .ce(ce),
        .reqValid(reqValid), .reqIn(reqIn), .reqReady(reqReady), .useRasOnly(useRasOnly),
        .rspValid(rspValid), .rspData(rspData), .pins(pins), .dqOut(dqOut), .dqOe(dqOe),
        .dqIn(dqIn));
    adai_dram_model adai_dram_model_inst (.pins(pins), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // request held from a falling edge until a rising edge sees ready
    task automatic doReq(input adai_pkg::adai_op_e op, input logic [15:0] a, input logic [3:0] w);
        reqIn = '{op, a, w};
        reqValid = 1'b1;
        for (int i = 0; i < 3000 && reqReady !== 1'b1; i++) @(negedge mclk);
        if (reqReady !== 1'b1) begin
            mismatches++;
            $display("unexpected request refused at %0t", $time);
        end
        @(negedge mclk);
        reqValid = 1'b0;
        // one idle edge, so the next call never raises valid in this time step
        @(negedge mclk);
    endtask
    // answers compared in order against the oldest note
    always @(negedge mclk) begin
        if (rspValid === 1'b1) begin
            n_checks++;
            if (expQ.size() == 0 || rspData !== expQ[0]) begin
                mismatches++;
                $display("unexpected read data at %0t", $time);
            end
            if (expQ.size() > 0) void'(expQ.pop_front());
        end
    end
    initial begin
        #400_000;
        mismatches++;
        $display("unexpected timeout at %0t", $time);
        print_verdict();
    end
    initial begin
        {reqValid, useRasOnly, reqIn, mismatches, n_checks} = '0;
        reset = 1'b1;
        ce = 1'b1;
        void'($urandom(88));
        repeat (12) @(negedge mclk);
        reset = 1'b0;
        for (int m = 0; m < 2; m++) begin
            useRasOnly = m[0];
            for (int k = 0; k < 4; k++) begin
                adr[k] = {8'($urandom), 6'($urandom), 2'(k)};
                if (k == 1) adr[k][15:8] = adr[0][15:8];  // same row, page hit
                dat[k] = 4'($urandom);
                doReq(adai_pkg::OP_WRITE, adr[k], dat[k]);
            end
            // a frozen stretch: pins hold, the stored words must survive it
            ce = 1'b0;
            repeat (9) @(negedge mclk);
            ce = 1'b1;
            // long idle so refreshes run over the stored words
            repeat (3500) @(negedge mclk);
            // read, modify-write with complement, read again
            for (int p = 0; p < 3; p++) begin
                for (int k = 0; k < 4; k++) begin
                    expQ.push_back(dat[k]);
                    doReq(p == 1 ? adai_pkg::OP_RMW : adai_pkg::OP_READ, adr[k], ~dat[k]);
                    if (p == 1) dat[k] = ~dat[k];
                end
            end
            $display("test %0d done", m);
        end
        // counter test: fill one column, so whatever row the counter holds reads back 4'hA
        for (int r = 0; r < 256; r++) doReq(adai_pkg::OP_WRITE, {8'(r), 8'h5A}, 4'hA);
        expQ.push_back(4'hA);
        doReq(adai_pkg::OP_TEST, {8'($urandom), 8'h5A}, 4'h5);
        $display("test counter done");
        for (int i = 0; i < 500 && expQ.size() > 0; i++) @(negedge mclk);
        if (expQ.size() > 0) mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
